// file: van_line_pkg.sv
// Shared constants for the line controller register port and its host bridge
package van_line_pkg;
   // Device register offsets
   localparam logic [6:0] DIAG_CTRL_OFS = 7'h02;
   localparam logic [6:0] CMD_OFS       = 7'h03;
   localparam logic [6:0] LINE_OFS      = 7'h04;
   localparam logic [6:0] LIVE_OFS      = 7'h05;
   localparam logic [6:0] LAST_OFS      = 7'h06;
   localparam logic [6:0] CHAN_BASE_OFS = 7'h10;
   // Diagnosis control fields
   localparam int DIV_SEL_LSB  = 4;
   localparam int IN_SEL_LSB   = 2;
   localparam int TIP_EN_BIT   = 1;
   localparam int DIV_EN_BIT   = 0;
   localparam logic [7:0] DIAG_CTRL_RST = 8'h00;
   // Command bits
   localparam int CMD_SOFT_GLOBAL_RESET_BIT  = 7;
   localparam int CMD_SLEEP_BIT = 6;
   localparam int CMD_IDLE_BIT  = 5;
   localparam int CMD_GO_ONLINE_CMD_BIT  = 4;
   localparam int CMD_REAR_BIT  = 3;
   localparam int CMD_MTICK_BIT = 0;
   localparam logic [7:0] CMD_RSVD_MASK = 8'h06;
   // Line status bits
   localparam int LS_SLEEP_BIT = 6;
   localparam int LS_IDLE_BIT  = 5;
   localparam int LS_MISM_BIT  = 4;
   localparam int LS_HLTH_LSB  = 2;
   localparam int LS_TXP_BIT   = 1;
   localparam int LS_BUSY_BIT  = 0;
   localparam logic [7:0] STAT_RST = 8'h00;
   // Input select codes
   localparam logic [1:0] SEL_DIFF = 2'h0;
   localparam logic [1:0] SEL_TWO  = 2'h1;
   localparam logic [1:0] SEL_ONE  = 2'h2;
   localparam logic [1:0] SEL_AUTO = 2'h3;
   // Timing: timeslot clock is mclk divided by sixteen
   localparam int TS_MCLK        = 16;
   localparam int CMD_DELAY_TS   = 6;
   localparam int TICK_HIGH_TS   = 2;
   localparam int DIV_BASE       = 64;
   // Host APB map
   localparam logic [7:0] APB_CTRL_OFS = 8'h00;
   localparam logic [7:0] APB_STAT_OFS = 8'h04;
   localparam int HC_ADDR_LSB  = 0;
   localparam int HC_DATA_LSB  = 8;
   localparam int HC_WRITE_BIT = 16;
   localparam int HC_WAKE_BIT  = 17;
   localparam int HS_BUSY_BIT  = 0;
   localparam int HS_REFUSE_BIT = 1;
   localparam int HS_RDATA_LSB = 8;
   typedef enum logic [2:0] {
      MODE_IDLE   = 3'b001,
      MODE_ACTIVE = 3'b010,
      MODE_SLEEP  = 3'b100
   } line_mode_t;
endpackage

// file: van_reg_if.sv
// Byte register port between the host bridge and the line controller
`timescale 1ns/1ps
interface van_reg_if;
   logic       sel;
   logic       wr;
   logic [6:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rvalid;
   logic       wakeReq;
   modport dev  (input sel, input wr, input addr, input wdata, input wakeReq, output rdata, output rvalid);
   modport host (output sel, output wr, output addr, output wdata, output wakeReq, input rdata, input rvalid);
endinterface

// file: van_line_dev.sv
// Line controller command, diagnosis control and status registers
// Behaviour
// RQ1: Input select bits pick receive source or auto
// RQ2: Enable bit gates transmission-in-progress indication
// RQ3: Enable bit runs the diagnosis tick divider
// RQ4: Host writes zero to reserved command bits
// RQ5: Commands take effect within six timeslots
// RQ6: Soft reset acts as pin reset, self-clears
// RQ7: Sleep stops oscillator and register access
// RQ8: Only pin reset or wake reset leaves sleep
// RQ9: Idle mode: no bus traffic, driver off
// RQ10: Activate command enables bus driver
// RQ11: Re-arbitrate after attempt, clearing retry count
// RQ12: Manual tick pulse high two timeslots
// RQ13: Line status read-only, resets idle
// RQ14: Health bits report diagnosis state
// RQ15: Mismatch flag sticky until frame end
// RQ16: Pending flag holds while message attempted
// RQ17: Host edits channels only when quiet; bridge checks only the last line status it read
// RQ18: Live register shows retries and channel
// RQ19: Last register shows last channel, retries
// RQ20: Diagnosis control layout, resets zero
// RQ21: Divider divides by sixty-four times power two
// RQ22: Frame end is a single pulse
// RQ23: Command bits act once, nothing readable
`timescale 1ns/1ps
module van_line_dev (
   input  wire logic  mclk,
   input  wire logic  nrst,
   van_reg_if.dev     regs,
   input  wire logic  lineInDiff,
   input  wire logic  lineInOne,
   input  wire logic  lineInTwo,
   input  wire logic  txData,
   input  wire logic  txActive,
   input  wire logic  txChosen,
   input  wire logic  txDone,
   input  wire logic  busActive,
   input  wire logic  endOfFramePulse,
   input  wire logic  attemptBusy,
   input  wire logic [1:0] lineHealth,
   input  wire logic [3:0] liveRetryCount,
   input  wire logic [3:0] liveTxChannel,
   input  wire logic  msgDone,
   input  wire logic  msgWasTx,
   input  wire logic [3:0] msgChannel,
   output logic       rxSelected,
   output logic       lineOut,
   output logic       lineOutOe,
   output logic       txInProgress,
   output logic       diagTick,
   output logic       redoArbitration,
   output logic       oscRun
);
   localparam logic [3:0] TS_LAST = 4'(van_line_pkg::TS_MCLK - 1);
   logic [3:0]  tsCnt_reg;
   logic        tsTick;
   logic        softRst_reg;
   logic        clr;
   logic [7:0]  diagCtrl_reg;
   logic [7:0]  cmdPend_reg;
   logic        cmdApply;
   van_line_pkg::line_mode_t mode_reg;
   logic        mismatch_reg;
   logic        txPending_reg;
   logic [7:0]  live_reg;
   logic [7:0]  last_reg;
   logic        rearbPend_reg;
   logic [21:0] divCnt_reg;
   logic [21:0] divLast;
   logic [1:0]  tickHold_reg;
   logic        tickStart;
   logic [1:0]  selEff;
   logic        inputsDiffer;
   logic [7:0]  lineStatus;
   logic [7:0]  rdata_reg;
   logic        rvalid_reg;
   logic        isSleep;
   logic        isActive;
   assign clr      = softRst_reg;
   assign isSleep  = (mode_reg == van_line_pkg::MODE_SLEEP);
   assign isActive = (mode_reg == van_line_pkg::MODE_ACTIVE);
   assign tsTick   = (tsCnt_reg == TS_LAST) && !isSleep;
   // Timeslot clock; frozen in sleep since the oscillator is stopped
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tsCnt_reg <= 4'h0;
      end else if (clr || isSleep) begin
         tsCnt_reg <= 4'h0;
      end else begin
         tsCnt_reg <= tsCnt_reg + 4'h1;
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         softRst_reg <= 1'b0;
      end else begin
         softRst_reg <= regs.wakeReq || (cmdApply && cmdPend_reg[van_line_pkg::CMD_SOFT_GLOBAL_RESET_BIT]); // see RQ6 RQ8
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         diagCtrl_reg <= van_line_pkg::DIAG_CTRL_RST;
      end else if (clr) begin
         diagCtrl_reg <= van_line_pkg::DIAG_CTRL_RST; // see RQ20
      end else if (regs.sel && regs.wr && !isSleep && regs.addr == van_line_pkg::DIAG_CTRL_OFS) begin
         diagCtrl_reg <= regs.wdata; // see RQ20
      end
   end
   assign cmdApply = tsTick && (cmdPend_reg != 8'h00); // see RQ5
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         cmdPend_reg <= 8'h00;
      end else if (clr) begin
         cmdPend_reg <= 8'h00;
      end else if (regs.sel && regs.wr && !isSleep && regs.addr == van_line_pkg::CMD_OFS) begin
         cmdPend_reg <= regs.wdata & ~van_line_pkg::CMD_RSVD_MASK; // see RQ23
      end else if (cmdApply) begin
         cmdPend_reg <= 8'h00; // see RQ23
      end
   end
   // Operating mode; sleep wins over idle, idle over activate
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= van_line_pkg::MODE_IDLE;
      end else if (clr) begin
         mode_reg <= van_line_pkg::MODE_IDLE; // see RQ13
      end else if (cmdApply) begin
         case (mode_reg)
            van_line_pkg::MODE_SLEEP: mode_reg <= van_line_pkg::MODE_SLEEP; // see RQ8
            van_line_pkg::MODE_IDLE, van_line_pkg::MODE_ACTIVE: begin
               if (cmdPend_reg[van_line_pkg::CMD_SLEEP_BIT]) begin
                  mode_reg <= van_line_pkg::MODE_SLEEP; // see RQ7
               end else if (cmdPend_reg[van_line_pkg::CMD_IDLE_BIT]) begin
                  mode_reg <= van_line_pkg::MODE_IDLE; // see RQ9
               end else if (cmdPend_reg[van_line_pkg::CMD_GO_ONLINE_CMD_BIT]) begin
                  mode_reg <= van_line_pkg::MODE_ACTIVE; // see RQ10
               end
            end
            default: mode_reg <= van_line_pkg::MODE_IDLE;
         endcase
      end
   end
   assign oscRun    = !isSleep; // see RQ7
   assign lineOutOe = isActive; // see RQ9 RQ10
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         lineOut <= 1'b0;
      end else begin
         lineOut <= isActive & txData;
      end
   end
   always_comb begin
      selEff = diagCtrl_reg[van_line_pkg::IN_SEL_LSB +: 2];
      if (selEff == van_line_pkg::SEL_AUTO) begin // see RQ1
         case (lineHealth)
            2'h1:    selEff = van_line_pkg::SEL_TWO;
            2'h2:    selEff = van_line_pkg::SEL_ONE;
            default: selEff = van_line_pkg::SEL_DIFF;
         endcase
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rxSelected <= 1'b0;
      end else begin
         case (selEff) // see RQ1
            van_line_pkg::SEL_TWO: rxSelected <= lineInTwo;
            van_line_pkg::SEL_ONE: rxSelected <= lineInOne;
            default:               rxSelected <= lineInDiff;
         endcase
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         txInProgress <= 1'b0;
      end else begin
         txInProgress <= txActive && isActive && diagCtrl_reg[van_line_pkg::TIP_EN_BIT]; // see RQ2
      end
   end
   assign divLast = 22'((van_line_pkg::DIV_BASE << diagCtrl_reg[van_line_pkg::DIV_SEL_LSB +: 4]) - 1); // see RQ21
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         divCnt_reg <= 22'h0;
      end else if (clr || !diagCtrl_reg[van_line_pkg::DIV_EN_BIT]) begin
         divCnt_reg <= 22'h0; // see RQ3
      end else if (tsTick) begin
         divCnt_reg <= (divCnt_reg >= divLast) ? 22'h0 : divCnt_reg + 22'h1;
      end
   end
   assign tickStart = (tsTick && diagCtrl_reg[van_line_pkg::DIV_EN_BIT] && divCnt_reg >= divLast) // see RQ3
                   || (cmdApply && cmdPend_reg[van_line_pkg::CMD_MTICK_BIT]); // see RQ12
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tickHold_reg <= 2'h0;
         diagTick     <= 1'b0;
      end else if (clr) begin
         tickHold_reg <= 2'h0;
         diagTick     <= 1'b0;
      end else if (tickStart) begin
         tickHold_reg <= 2'(van_line_pkg::TICK_HIGH_TS); // see RQ12
         diagTick     <= 1'b1;
      end else if (tsTick && tickHold_reg != 2'h0) begin
         tickHold_reg <= tickHold_reg - 2'h1;
         diagTick     <= (tickHold_reg != 2'h1);
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rearbPend_reg   <= 1'b0;
         redoArbitration <= 1'b0;
      end else if (clr) begin
         rearbPend_reg   <= 1'b0;
         redoArbitration <= 1'b0;
      end else begin
         redoArbitration <= rearbPend_reg && !attemptBusy; // see RQ11
         rearbPend_reg   <= (cmdApply && cmdPend_reg[van_line_pkg::CMD_REAR_BIT]) || (rearbPend_reg && attemptBusy);
      end
   end
   // Sticky flags: the set beats a same-cycle clear
   assign inputsDiffer = !((lineInDiff == lineInOne) && (lineInOne == lineInTwo));
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         mismatch_reg  <= 1'b0;
         txPending_reg <= 1'b0;
      end else if (clr) begin
         mismatch_reg  <= 1'b0; // see RQ15
         txPending_reg <= 1'b0;
      end else begin
         mismatch_reg  <= inputsDiffer || (mismatch_reg && !endOfFramePulse); // see RQ15 RQ22
         txPending_reg <= txChosen || (txPending_reg && !txDone); // see RQ16
      end
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         live_reg <= van_line_pkg::STAT_RST;
         last_reg <= van_line_pkg::STAT_RST;
      end else if (clr) begin
         live_reg <= van_line_pkg::STAT_RST;
         last_reg <= van_line_pkg::STAT_RST;
      end else begin
         live_reg <= {liveRetryCount, liveTxChannel}; // see RQ18
         if (msgDone) begin
            // Retries are meaningless after a reception; zero is shown
            last_reg <= {msgWasTx ? liveRetryCount : 4'h0, msgChannel}; // see RQ19
         end
      end
   end
   assign lineStatus = {1'b0, isSleep, mode_reg == van_line_pkg::MODE_IDLE, mismatch_reg,
                        lineHealth, txPending_reg, busActive}; // see RQ13 RQ14 RQ17
   // Read port answers one cycle after select; sleep blocks access
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rdata_reg  <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= regs.sel;
         rdata_reg  <= 8'h00;
         if (regs.sel && !regs.wr && !isSleep) begin // see RQ7
            case (regs.addr)
               van_line_pkg::DIAG_CTRL_OFS: rdata_reg <= diagCtrl_reg;
               van_line_pkg::LINE_OFS:      rdata_reg <= lineStatus;
               van_line_pkg::LIVE_OFS:      rdata_reg <= live_reg;
               van_line_pkg::LAST_OFS:      rdata_reg <= last_reg;
               default:                     rdata_reg <= 8'h00; // see RQ23
            endcase
         end
      end
   end
   assign regs.rdata  = rdata_reg;
   assign regs.rvalid = rvalid_reg;
endmodule

// file: van_line_host.sv
// Host bridge: APB slave that issues byte accesses to the line controller
`timescale 1ns/1ps
module van_line_host (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   van_reg_if.host          regs
);
   logic       busy_reg;
   logic       refused_reg;
   logic [7:0] rdByte_reg;
   logic [7:0] lineShadow_reg;
   logic       sel_reg;
   logic       wr_reg;
   logic [6:0] addr_reg;
   logic [7:0] wdata_reg;
   logic       wake_reg;
   logic       apbWr;
   logic       apbRd;
   logic       ctrlWr;
   logic [6:0] reqAddr;
   logic       chanBlocked;

   assign apbWr   = psel && penable && pwrite;
   assign apbRd   = psel && penable && !pwrite;
   assign ctrlWr  = apbWr && paddr == van_line_pkg::APB_CTRL_OFS;
   assign reqAddr = pwdata[van_line_pkg::HC_ADDR_LSB +: 7];
   // Channel set writes are refused while the last line status read shows transmit pending or bus busy
   assign chanBlocked = pwdata[van_line_pkg::HC_WRITE_BIT] && reqAddr >= van_line_pkg::CHAN_BASE_OFS
                     && (lineShadow_reg[van_line_pkg::LS_TXP_BIT] || lineShadow_reg[van_line_pkg::LS_BUSY_BIT]); // see RQ17

   assign pready  = 1'b1;
   assign pslverr = psel && penable && paddr != van_line_pkg::APB_CTRL_OFS && paddr != van_line_pkg::APB_STAT_OFS;
   always_comb begin
      prdata = 32'h0;
      if (apbRd && paddr == van_line_pkg::APB_STAT_OFS) begin
         prdata[van_line_pkg::HS_BUSY_BIT]        = busy_reg;
         prdata[van_line_pkg::HS_REFUSE_BIT]      = refused_reg;
         prdata[van_line_pkg::HS_RDATA_LSB +: 8]  = rdByte_reg;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         busy_reg       <= 1'b0;
         refused_reg    <= 1'b0;
         rdByte_reg     <= 8'h00;
         lineShadow_reg <= 8'h00;
         sel_reg        <= 1'b0;
         wr_reg         <= 1'b0;
         addr_reg       <= 7'h0;
         wdata_reg      <= 8'h00;
         wake_reg       <= 1'b0;
      end else begin
         sel_reg  <= 1'b0;
         wake_reg <= 1'b0;
         if (ctrlWr && !busy_reg) begin
            if (pwdata[van_line_pkg::HC_WAKE_BIT]) begin
               wake_reg <= 1'b1; // see RQ8
            end else if (chanBlocked) begin
               refused_reg <= 1'b1;
            end else begin
               refused_reg <= 1'b0;
               sel_reg     <= 1'b1;
               busy_reg    <= 1'b1;
               wr_reg      <= pwdata[van_line_pkg::HC_WRITE_BIT];
               addr_reg    <= reqAddr;
               // Reserved command bits always go out as zero
               wdata_reg   <= (reqAddr == van_line_pkg::CMD_OFS) // see RQ4
                  ? pwdata[van_line_pkg::HC_DATA_LSB +: 8] & ~van_line_pkg::CMD_RSVD_MASK
                  : pwdata[van_line_pkg::HC_DATA_LSB +: 8];
            end
         end else if (busy_reg && regs.rvalid) begin
            busy_reg <= 1'b0;
            if (!wr_reg) begin
               rdByte_reg <= regs.rdata;
               if (addr_reg == van_line_pkg::LINE_OFS) begin
                  lineShadow_reg <= regs.rdata; // see RQ5 RQ17
               end
            end
         end
      end
   end

   assign regs.sel     = sel_reg;
   assign regs.wr      = wr_reg;
   assign regs.addr    = addr_reg;
   assign regs.wdata   = wdata_reg;
   assign regs.wakeReq = wake_reg;
endmodule

// file: van_line_properties.sv
// Checker for the byte register port between host bridge and line controller
`timescale 1ns/1ps
module van_line_properties (
   input wire logic       mclk,
   input wire logic       nrst,
   input wire logic       sel,
   input wire logic       wr,
   input wire logic [6:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata,
   input wire logic       rvalid,
   input wire logic       wakeReq
);
   logic [7:0] diagShadow;
   logic [4:0] sleepAge;
   logic       freshMode;
   logic       rd;
   logic       cmdWr;
   logic       softRst;
   logic [4:0] gresAge;
   assign rd = sel && !wr;
   assign cmdWr = sel && wr && addr == van_line_pkg::CMD_OFS;
   assign softRst = wakeReq || gresAge == 5'd17;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   // Soft reset clears the device within seventeen cycles, never while asleep
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) gresAge <= 5'd0;
      else if (softRst) gresAge <= 5'd0;
      else if (gresAge != 5'd0 || (cmdWr && wdata[7] && sleepAge == 5'd0)) gresAge <= gresAge + 5'd1;
   end
   // Sleep drops writes
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) diagShadow <= 8'h00;
      else if (softRst) diagShadow <= 8'h00;
      else if (sel && wr && addr == van_line_pkg::DIAG_CTRL_OFS && sleepAge == 5'd0) diagShadow <= wdata;
   end
   // Saturates past the worst command delay
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) sleepAge <= 5'd0;
      else if (softRst) sleepAge <= 5'd0;
      else if (cmdWr && wdata[6]) sleepAge <= 5'd1;
      else if (sleepAge != 5'd0 && sleepAge != 5'd31) sleepAge <= sleepAge + 5'd1;
   end
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) freshMode <= 1'b1;
      else if (softRst) freshMode <= 1'b1;
      else if (cmdWr && (wdata[6] || wdata[4])) freshMode <= 1'b0;
   end
   a_answer_next: assert property (sel |=> rvalid) else $error("no answer after access");
   a_answer_cause: assert property (rvalid |-> $past(sel)) else $error("answer without access");
   a_cmd_reads_zero: assert property (rd && addr == van_line_pkg::CMD_OFS |=> rdata == 8'h00)
      else $error("command register readable");
   a_unmapped_zero: assert property (rd && (addr > van_line_pkg::LAST_OFS || addr < 7'h02)
      |=> rdata == 8'h00) else $error("absent address not zero");
   a_status_top_clear: assert property (rd && addr == van_line_pkg::LINE_OFS
      |=> !rdata[7] && !(rdata[6] && rdata[5])) else $error("line state mode bits wrong");
   a_diag_readback: assert property (rd && addr == van_line_pkg::DIAG_CTRL_OFS && sleepAge == 5'd0
      && gresAge == 5'd0 |=> rdata == diagShadow) else $error("diag control readback wrong");
   a_sleep_silent: assert property (rd && sleepAge == 5'd31 |=> rdata == 8'h00)
      else $error("read served in sleep");
   a_reset_idle: assert property (rd && addr == van_line_pkg::LINE_OFS && freshMode
      |=> rdata[6:5] == 2'b01) else $error("not idle after reset");
   c_sleep: cover property (cmdWr && wdata[6]);
   c_wake: cover property (wakeReq);
   c_live: cover property (rd && addr == van_line_pkg::LIVE_OFS);
endmodule

// file: tb_van_line_command_status_regs.sv
// Self-checking bench for the line controller joined to its APB host bridge
`timescale 1ns/1ps
module tb_van_line_command_status_regs;
   logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]  paddr, q;
   logic [31:0] pwdata, prdata, s;
   logic        lineInDiff, lineInOne, lineInTwo, txData, txActive, txChosen, txDone, busActive;
   logic        endOfFramePulse, attemptBusy, msgDone, msgWasTx;
   logic [1:0]  lineHealth, h;
   logic [3:0]  liveRetryCount, liveTxChannel, msgChannel, r, c;
   logic        rxSelected, lineOut, lineOutOe, txInProgress, diagTick, redoArbitration, oscRun;
   int          errors, nChecks, seed, n1, n2;
   localparam logic [6:0] K_DIAG = van_line_pkg::DIAG_CTRL_OFS;
   localparam logic [6:0] K_CMD = van_line_pkg::CMD_OFS;
   localparam logic [6:0] K_LINE = van_line_pkg::LINE_OFS;
   van_reg_if regIf ();
   van_line_host u_van_line_host (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .regs(regIf));
   van_line_dev u_van_line_dev (.mclk, .nrst, .regs(regIf), .lineInDiff, .lineInOne, .lineInTwo, .txData,
      .txActive, .txChosen, .txDone, .busActive, .endOfFramePulse, .attemptBusy, .lineHealth, .liveRetryCount,
      .liveTxChannel, .msgDone, .msgWasTx, .msgChannel, .rxSelected, .lineOut, .lineOutOe, .txInProgress,
      .diagTick, .redoArbitration, .oscRun);
   van_line_properties u_van_line_properties (.mclk, .nrst, .sel(regIf.sel), .wr(regIf.wr), .addr(regIf.addr),
      .wdata(regIf.wdata), .rdata(regIf.rdata), .rvalid(regIf.rvalid), .wakeReq(regIf.wakeReq));
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] rd);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do @(posedge mclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Device access is posted: busy is polled before the byte is trusted
   task automatic dev(input logic [6:0] a, input logic w, input logic [7:0] d, output logic [7:0] rb);
      logic [31:0] t;
      apb(van_line_pkg::APB_CTRL_OFS, 1'b1, {15'h0, w, d, 1'b0, a}, t);
      do apb(van_line_pkg::APB_STAT_OFS, 1'b0, 32'h0, t); while (t[van_line_pkg::HS_BUSY_BIT] !== 1'b0);
      rb = t[15:8];
   endtask
   task automatic settle();
      repeat (van_line_pkg::CMD_DELAY_TS * van_line_pkg::TS_MCLK) @(posedge mclk);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nChecks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic waitTick(input logic lvl, input int lim, output int n);
      n = 0;
      while (diagTick !== lvl && n < lim) begin
         @(posedge mclk);
         n++;
      end
   endtask
   task automatic countRedo(input int lim, output int k);
      k = 0;
      repeat (lim) begin
         @(posedge mclk);
         k += (redoArbitration === 1'b1);
      end
   endtask
   function automatic logic selExp(input logic [1:0] code, input logic [1:0] hl);
      logic [1:0] k;
      k = code;
      if (code == van_line_pkg::SEL_AUTO) begin
         k = (hl == 2'h1) ? van_line_pkg::SEL_TWO : (hl == 2'h2) ? van_line_pkg::SEL_ONE : van_line_pkg::SEL_DIFF;
      end
      return (k == van_line_pkg::SEL_TWO) ? lineInTwo : (k == van_line_pkg::SEL_ONE) ? lineInOne : lineInDiff;
   endfunction
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      errors++;
      $display("BAD %0t watchdog expired", $time);
      give_verdict();
   end
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata, txData, txActive, txChosen, txDone, busActive} = '0;
      {endOfFramePulse, attemptBusy, msgDone, msgWasTx, lineHealth, liveRetryCount, liveTxChannel, msgChannel} = '0;
      {lineInDiff, lineInOne, lineInTwo} = 3'b111;
      {errors, nChecks} = '0;
      seed = 26108;
      repeat (10) @(posedge mclk);
      nrst <= 1'b1;
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q, 8'h20);
      dev(K_DIAG, 1'b0, 8'h00, q);
      chk(q, van_line_pkg::DIAG_CTRL_RST);
      dev(van_line_pkg::LIVE_OFS, 1'b0, 8'h00, q);
      chk(q, 8'h00);
      dev(van_line_pkg::LAST_OFS, 1'b0, 8'h00, q);
      chk(q, 8'h00);
      apb(8'h08, 1'b0, 32'h0, s);
      chk(err, 1'b1);
      $display("reset values done");
      for (int code = 0; code < 4; code++) begin
         repeat (3) begin
            q = $random(seed);
            {lineInDiff, lineInOne, lineInTwo, lineHealth} <= q[4:0];
            dev(K_DIAG, 1'b1, {q[7:4], code[1:0], 2'b00}, q);
            @(posedge mclk);
            chk(rxSelected, selExp(code[1:0], lineHealth));
         end
      end
      $display("input select done");
      {lineInDiff, lineInOne, lineInTwo} <= 3'b111;
      h = $random(seed);
      lineHealth <= h;
      busActive <= 1'b1;
      endOfFramePulse <= 1'b1;
      txChosen <= 1'b1;
      @(posedge mclk);
      {endOfFramePulse, txChosen} <= 2'b00;
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q, {4'h2, h, 2'b11});
      lineInOne <= 1'b0;
      txDone <= 1'b1;
      @(posedge mclk);
      {lineInOne, txDone, busActive} <= 3'b100;
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q, {4'h3, h, 2'b00});
      endOfFramePulse <= 1'b1;
      @(posedge mclk);
      endOfFramePulse <= 1'b0;
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q, {4'h2, h, 2'b00});
      $display("line state done");
      for (int i = 0; i < 4; i++) begin
         {r, c, h} = $random(seed);
         {liveRetryCount, liveTxChannel, msgChannel, msgWasTx, msgDone} <= {r, c, c + 4'h1, i[0], 1'b1};
         @(posedge mclk);
         msgDone <= 1'b0;
         dev(van_line_pkg::LIVE_OFS, 1'b0, 8'h00, q);
         chk(q, {r, c});
         dev(van_line_pkg::LAST_OFS, 1'b0, 8'h00, q);
         chk(q, {i[0] ? r : 4'h0, c + 4'h1});
      end
      $display("message state done");
      dev(K_CMD, 1'b1, 8'h10, q);
      settle();
      chk(lineOutOe, 1'b1);
      txData <= 1'b1;
      txActive <= 1'b1;
      dev(K_DIAG, 1'b1, 8'h02, q);
      chk({lineOut, txInProgress}, 2'b11);
      dev(K_DIAG, 1'b1, 8'h00, q);
      chk(txInProgress, 1'b0);
      dev(K_CMD, 1'b1, 8'h20, q);
      settle();
      chk(lineOutOe, 1'b0);
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q[6:5], 2'b01);
      $display("modes done");
      dev(K_CMD, 1'b1, 8'h01, q);
      waitTick(1'b1, 40, n1);
      waitTick(1'b0, 200, n1);
      chk(n1 >= van_line_pkg::TICK_HIGH_TS * van_line_pkg::TS_MCLK, 1'b1);
      dev(K_DIAG, 1'b1, 8'h01, q);
      waitTick(1'b1, 1200, n1);
      waitTick(1'b0, 200, n1);
      waitTick(1'b1, 1200, n2);
      chk(n1 + n2 == van_line_pkg::DIV_BASE * van_line_pkg::TS_MCLK, 1'b1);
      dev(K_DIAG, 1'b1, 8'h00, q);
      waitTick(1'b0, 200, n1);
      waitTick(1'b1, 1100, n1);
      chk(n1 == 1100, 1'b1);
      $display("diagnosis tick done");
      attemptBusy <= 1'b1;
      dev(K_CMD, 1'b1, 8'h08, q);
      countRedo(40, n1);
      attemptBusy <= 1'b0;
      countRedo(40, n2);
      chk({n1[3:0], n2[3:0]}, 8'h01);
      dev(K_DIAG, 1'b1, 8'hf4, q);
      dev(K_CMD, 1'b1, 8'h80, q);
      settle();
      dev(K_DIAG, 1'b0, 8'h00, q);
      chk(q, 8'h00);
      dev(K_DIAG, 1'b1, 8'h04, q);
      dev(K_CMD, 1'b1, 8'h40, q);
      settle();
      chk(oscRun, 1'b0);
      dev(K_DIAG, 1'b0, 8'h00, q);
      chk(q, 8'h00);
      apb(van_line_pkg::APB_CTRL_OFS, 1'b1, 32'h1 << van_line_pkg::HC_WAKE_BIT, s);
      repeat (4) @(posedge mclk);
      chk(oscRun, 1'b1);
      dev(K_LINE, 1'b0, 8'h00, q);
      chk(q[6:5], 2'b01);
      $display("reset and sleep done");
      give_verdict();
   end
endmodule
